// ---- testbench.sv ----
// Testbench of the two-speed start-up block: bus tasks, edge counters, scenarios.
// Assumes tsc_pkg, the start-up block and the oscillator model are compiled first.
`timescale 1ns/1ps
module testbench;
    localparam int PLL_N = 50;
    logic              clk_sys_i       = 1'b0;
    logic              srst_i          = 1'b1;
    logic              sleep_i         = 1'b0;
    logic              wake_i          = 1'b0;
    logic              power_up_timer_done       = 1'b0;
    logic              ext_en          = 1'b0;
    logic [1:0]        ext_half        = 2'h2;
    logic              ext_d           = 1'b0;
    logic              t1_d            = 1'b0;
    tsc_pkg::tsc_bus_s bus             = '0;
    tsc_pkg::tsc_osc_s osc;
    tsc_pkg::tsc_src_e src_o;
    logic [7:0]        rdata_o;
    logic              sys_clk_o;
    logic              run_o;
    logic              ext_running_o;
    logic              pll_rdy_o;
    int                ext_n           = 0;
    int                t1_n            = 0;
    int                fails           = 0;
    int                samples_checked = 0;
    logic [7:0]        cfgs [10]       = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
                                           8'h0d, 8'h0e, 8'h0f, 8'h02, 8'h12};

    always #4 clk_sys_i = ~clk_sys_i;

    tsc_startup #(.PLL_CYC(PLL_N)) uut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata_o),
        .osc_i(osc), .sleep_i(sleep_i), .wake_i(wake_i), .power_up_timer_expired_i(power_up_timer_done),
        .sys_clk_o(sys_clk_o), .src_o(src_o), .run_o(run_o),
        .ext_running_o(ext_running_o), .pll_rdy_o(pll_rdy_o));

    tsc_osc_model osc_model (.clk_sys_i(clk_sys_i), .ext_en_i(ext_en),
        .ext_half_i(ext_half), .osc_o(osc));

    // Edges counted as the block samples them; the counters run a cycle loose
    always @(posedge clk_sys_i) begin
        ext_d <= osc.ext;
        t1_d <= osc.t1;
        if (osc.ext && !ext_d) ext_n = ext_n + 1;
        if (osc.t1 && !t1_d) t1_n = t1_n + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic in_rng(input int v, input int lo, input int hi, input string what);
        chk(32'(v >= lo && v <= hi), 32'h0000_0001, what);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1;
        chk(rdata_o, exp, what);
    endtask

    task automatic pulse(input logic is_wake);
        @(posedge clk_sys_i);
        wake_i <= is_wake;
        sleep_i <= !is_wake;
        @(posedge clk_sys_i);
        wake_i <= 1'b0;
        sleep_i <= 1'b0;
        ext_n = 0;
        t1_n = 0;
    endtask

    // sel 0 run, 1 flag, 2 multiplier ready, 3 and up source code plus 3
    task automatic wait_on(input int sel, input int bound, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            case (sel)
                0: hit = (run_o === 1'b1);
                1: hit = (ext_running_o === 1'b1);
                2: hit = (pll_rdy_o === 1'b1);
                default: hit = (src_o === tsc_pkg::tsc_src_e'(sel - 3));
            endcase
            if (!hit && n >= bound) begin
                fails++;
                $display("unexpected at %0t: wait %0d timed out", $time, sel);
                report_and_stop();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int e0;
        int r;
        logic sc;
        logic [2:0] mode;
        logic two;
        void'($urandom(59));
        repeat (4) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        power_up_timer_done <= 1'b1;
        rd(tsc_pkg::ADDR_CFG, 8'h0a, "cfg reset");
        rd(tsc_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00, "unmapped");
        // Crystal absent: the core must keep running on the internal block
        wait_on(0, 700, n);
        chk(src_o, tsc_pkg::SRC_HF, "por source");
        repeat (1500) @(posedge clk_sys_i);
        chk(ext_running_o, 1'b0, "flag without crystal");
        ext_en <= 1'b1;
        repeat (200) @(posedge clk_sys_i);
        pulse(1'b0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(run_o, 1'b0, "run after sleep");
        repeat (5000) @(posedge clk_sys_i);
        chk(ext_running_o, 1'b0, "flag after abort");
        foreach (cfgs[i]) begin
            mode = cfgs[i][2:0];
            two = (cfgs[i][3] || cfgs[i][4]) && mode < 3'h3;
            ext_half <= 2'($urandom % 3 + 1);
            wr(tsc_pkg::ADDR_CFG, cfgs[i]);
            pulse(1'b1);
            wait_on(0, 7000, n);
            if (two || mode == 3'h4) begin
                in_rng(n, 624, 630, "warm-up wait");
                chk(src_o, tsc_pkg::SRC_HF, "early source");
                chk(ext_running_o, 1'b0, "early flag");
            end else if (mode < 3'h3) begin
                in_rng(ext_n, 1023, 1028, "crystal wait");
                chk(src_o, tsc_pkg::SRC_EXT, "crystal source");
            end else begin
                in_rng(ext_n, 2, 4, "ext clock wait");
                chk(src_o, tsc_pkg::SRC_EXT, "ext clock source");
            end
            if (two) begin
                wait_on(1, 7000, n);
                in_rng(ext_n, 1023, 1028, "flag count");
                wait_on(5, 40, n);
                rd(tsc_pkg::ADDR_STAT, 8'h25, "status");
            end
            pulse(1'b0);
            repeat (2) @(posedge clk_sys_i);
            #1;
            chk(ext_running_o, 1'b0, "flag on sleep");
            chk(run_o, 1'b0, "run on sleep");
        end
        wr(tsc_pkg::ADDR_CFG, 8'h0a);
        pulse(1'b1);
        wait_on(1, 7000, n);
        wait_on(5, 40, n);
        e0 = ext_n;
        r = 0;
        sc = sys_clk_o;
        repeat (64) begin
            @(posedge clk_sys_i);
            #1;
            if (sys_clk_o && !sc) r++;
            sc = sys_clk_o;
        end
        in_rng(r - (ext_n - e0), -1, 1, "clock pulses");
        wr(tsc_pkg::ADDR_CTRL, 8'h08);
        wait_on(2, 200, n);
        in_rng(n, PLL_N - 1, PLL_N + 1, "multiplier wait");
        wr(tsc_pkg::ADDR_CTRL, 8'h01);
        t1_n = 0;
        wait_on(6, 9500, n);
        in_rng(t1_n, 1023, 1028, "timer osc wait");
        chk(pll_rdy_o, 1'b0, "multiplier off");
        wr(tsc_pkg::ADDR_CTRL, 8'h02);
        wait_on(3, 400, n);
        in_rng(n, 249, 266, "internal switch");
        wr(tsc_pkg::ADDR_CTRL, 8'h06);
        wait_on(4, 300, n);
        wr(tsc_pkg::ADDR_CFG, 8'h0b);
        wr(tsc_pkg::ADDR_CTRL, 8'h00);
        wait_on(5, 40, n);
        in_rng(n, 3, 26, "low-freq to external switch");
        rd(tsc_pkg::ADDR_CTRL, 8'h00, "ctrl back");
        // A second power-on in mid-run restarts the whole start-up sequence
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk({run_o, ext_running_o, pll_rdy_o}, 32'h0000_0000, "reset flags");
        wait_on(0, 700, n);
        in_rng(n, 624, 630, "warm-up after reset");
        chk(src_o, tsc_pkg::SRC_HF, "source after reset");
        report_and_stop();
    end
endmodule

// ---- tsc_osc_model.sv ----
// Oscillator model: free-running internal oscillators, a gated external one.
// Assumes the start-up block samples these levels on clk_sys_i.
`timescale 1ns/1ps
module tsc_osc_model (
    input  wire logic        clk_sys_i,  // System clock
    input  wire logic        ext_en_i,   // External oscillator powered
    input  wire logic [1:0]  ext_half_i, // External half period in cycles
    output tsc_pkg::tsc_osc_s osc_o      // Oscillator levels
);
    int cnt_i = 0;
    int cnt_e = 0;

    initial osc_o = '0;

    ////////////////////////////////////////////////////////////////////////////
    // A crystal that is not powered does not swing, so its level stays low
    always @(posedge clk_sys_i) begin
        cnt_i <= cnt_i + 1;
        osc_o.hf <= ~osc_o.hf;
        if (cnt_i % 4 == 3) osc_o.t1 <= ~osc_o.t1;
        if (cnt_i % 8 == 7) osc_o.lf <= ~osc_o.lf;
        if (!ext_en_i) begin
            osc_o.ext <= 1'b0;
            cnt_e <= 0;
        end else if (cnt_e + 1 >= int'(ext_half_i)) begin
            osc_o.ext <= ~osc_o.ext;
            cnt_e <= 0;
        end else begin
            cnt_e <= cnt_e + 1;
        end
    end
endmodule

// ---- tsc_ost.sv ----
// Start-up timer: counts rising edges of a sampled oscillator up to the stable count.
// Assumes the oscillator level is already synchronous to clk_sys_i.
`timescale 1ns/1ps
module tsc_ost (
    input  wire logic clk_sys_i, // System clock
    input  wire logic srst_i,    // Synchronous reset
    input  wire logic clr_i,     // Restart the count
    input  wire logic osc_i,     // Sampled oscillator level
    output logic      done_o     // Stable count reached
);

    tsc_pkg::tsc_ost_s r;
    tsc_pkg::tsc_ost_s next_r;

    always_comb begin
        next_r      = r;
        next_r.prev = osc_i;
        if (clr_i) begin
            next_r.cnt  = 11'h000;
            next_r.done = 1'b0;
        end else if (osc_i && !r.prev && !r.done) begin
            next_r.cnt  = r.cnt + 11'h001;
            next_r.done = (r.cnt == 11'(tsc_pkg::OST_COUNT - 1));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done_o = r.done;

    a_ost_full_count: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $rose(r.done) |-> $past(r.cnt) == 11'(tsc_pkg::OST_COUNT - 1))
        else $error("start-up timer finished before the full count");

endmodule

// ---- tsc_pkg.sv ----
// Package of the two-speed clock start-up block: constants, encodings, carriers.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package tsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ        = 125;
    localparam int OST_COUNT      = 1024;
    localparam int EXT_WAKE_EDGES = 2;
    localparam int INT_SW_NS      = 2000;
    localparam int INT_SW_CYC     = (INT_SW_NS * CLK_MHZ + 999) / 1000;
    localparam int PLL_LOCK_US    = 2000;
    localparam int PLL_LOCK_CYC   = PLL_LOCK_US * CLK_MHZ;
    localparam int WARM_NS        = 5000;
    localparam int WARM_CYC       = (WARM_NS * CLK_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [3:0] ADDR_CFG  = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;

    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_SWITCHOVER = 3;
    localparam int CFG_FAIL_SAFE_CLOCK_MONITOR       = 4;
    localparam int CFG_POWER_UP_TIMER       = 5;
    localparam int CTRL_SCS_LSB   = 0;
    localparam int CTRL_LF        = 2;
    localparam int CTRL_PLL       = 3;
    localparam int STAT_FLAG      = 0;
    localparam int STAT_PLL       = 1;
    localparam int STAT_RUN       = 2;
    localparam int STAT_SRC_LSB   = 4;

    localparam logic [5:0] CFG_RST  = 6'h0a;
    localparam logic [3:0] CTRL_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [2:0] {
        MODE_LP  = 3'b000,
        MODE_XT  = 3'b001,
        MODE_HS  = 3'b010,
        MODE_RC  = 3'b011,
        MODE_INT = 3'b100
    } tsc_mode_e;

    typedef enum logic [1:0] {
        SRC_HF  = 2'b00,
        SRC_LF  = 2'b01,
        SRC_EXT = 2'b10,
        SRC_T1  = 2'b11
    } tsc_src_e;

    typedef enum logic [2:0] {
        ST_POR   = 3'b000,
        ST_SLEEP = 3'b001,
        ST_WAKE  = 3'b010,
        ST_TWO   = 3'b011,
        ST_RUN   = 3'b100,
        ST_PREP  = 3'b101,
        ST_OLD   = 3'b110,
        ST_NEW   = 3'b111
    } tsc_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tsc_bus_s;

    // Bit order matches tsc_src_e so a source code indexes the vector
    typedef struct packed {
        logic t1;
        logic ext;
        logic lf;
        logic hf;
    } tsc_osc_s;

    typedef struct packed {
        logic        prev;
        logic [10:0] cnt;
        logic        done;
    } tsc_ost_s;

    typedef struct packed {
        tsc_state_e  st;
        tsc_src_e    src;
        tsc_src_e    tgt;
        logic [9:0]  cnt;
        logic [17:0] pll_cnt;
        logic        pll_rdy;
        logic        flag;
        logic        run;
        logic        clk_out;
        logic [3:0]  prev;
        logic [5:0]  cfg;
        logic [3:0]  ctrl;
        logic [7:0]  rdata;
    } tsc_state_s;

endpackage

// ---- tsc_startup.sv ----
// Two-speed clock start-up and clock source switching for the core clock.
// Assumes oscillator levels and core events are synchronous to clk_sys_i,
// and that the power-up timer is outside and reports its expiry as a level.
//
// How it works
// - crystal modes need 1024 oscillations before use
// - two-speed off for non-crystal oscillator modes
// - core runs on internal oscillator meanwhile
// - count done sets flag, switches to external
// - sleep before count done aborts, flag clear
// - needs switchover bit, select 00, crystal mode
// - starts after power-up timer and wake
// - fail-safe monitor also enables two-speed
// - external clock or RC wake waits two cycles
// - low-freq to external: one cycle each
// - wake onto crystal or timer osc waits 1024
// - switch to internal block takes 2 us
// - switch from run state to timer osc waits 1024
// - multiplier ready about 2 ms after enable
// - wake onto internal osc waits warm-up
`timescale 1ns/1ps
module tsc_startup #(
    parameter int PLL_CYC = tsc_pkg::PLL_LOCK_CYC
) (
    input  wire logic               clk_sys_i,      // System clock
    input  wire logic               srst_i,         // Synchronous reset, power-on
    input  wire tsc_pkg::tsc_bus_s  bus_i,          // Register request
    output logic [7:0]              rdata_o,        // Read data, cycle after read
    input  wire tsc_pkg::tsc_osc_s  osc_i,          // Oscillator levels
    input  wire logic               sleep_i,        // Sleep instruction pulse
    input  wire logic               wake_i,         // Wake-up event pulse
    input  wire logic               power_up_timer_expired_i, // Power-up timer expired
    output logic                    sys_clk_o,      // Selected core clock
    output tsc_pkg::tsc_src_e       src_o,          // Source now clocking core
    output logic                    run_o,          // Core may execute
    output logic                    ext_running_o,  // External oscillator running
    output logic                    pll_rdy_o       // Multiplier output usable
);

    tsc_pkg::tsc_state_s r;
    tsc_pkg::tsc_state_s next_r;

    logic [3:0]        osc_v;
    logic [3:0]        rise;
    logic [3:0]        fall;
    logic              ext_done;
    logic              t1_done;
    logic              ost_clr;
    logic              t1_clr;
    logic              xtal;
    logic              ts_en;
    logic              lim_hit;
    tsc_pkg::tsc_src_e want;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic logic is_xtal(input logic [5:0] cfg);
        logic [2:0] m;
        m = cfg[tsc_pkg::CFG_MODE_LSB +: 3];
        return m == tsc_pkg::MODE_LP || m == tsc_pkg::MODE_XT || m == tsc_pkg::MODE_HS;
    endfunction

    function automatic tsc_pkg::tsc_src_e want_src(input logic [5:0] cfg,
                                                   input logic [3:0] ctrl);
        logic [1:0] system_clock_select;
        system_clock_select = ctrl[tsc_pkg::CTRL_SCS_LSB +: 2];
        if (system_clock_select == 2'b01) begin
            return tsc_pkg::SRC_T1;
        end else if (system_clock_select[1] || cfg[tsc_pkg::CFG_MODE_LSB +: 3] == tsc_pkg::MODE_INT) begin
            return ctrl[tsc_pkg::CTRL_LF] ? tsc_pkg::SRC_LF : tsc_pkg::SRC_HF;
        end
        return tsc_pkg::SRC_EXT;
    endfunction

    assign osc_v = osc_i;
    assign rise  = osc_v & ~r.prev;
    assign fall  = ~osc_v & r.prev;
    assign xtal  = is_xtal(r.cfg);
    assign want  = want_src(r.cfg, r.ctrl);
    assign ts_en = (r.cfg[tsc_pkg::CFG_SWITCHOVER] || r.cfg[tsc_pkg::CFG_FAIL_SAFE_CLOCK_MONITOR])
                && r.ctrl[tsc_pkg::CTRL_SCS_LSB +: 2] == 2'b00 && xtal;

    // Timers restart as a start-up period begins; the timer oscillator also
    // restarts when software asks to move onto it while in the run state
    assign ost_clr = (r.st == tsc_pkg::ST_POR
                      && (!r.cfg[tsc_pkg::CFG_POWER_UP_TIMER] || power_up_timer_expired_i))
                  || (r.st == tsc_pkg::ST_SLEEP && wake_i);
    assign t1_clr  = ost_clr || (r.st == tsc_pkg::ST_RUN && want == tsc_pkg::SRC_T1
                                 && r.src != tsc_pkg::SRC_T1);

    tsc_ost u_ext_ost (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .clr_i     (ost_clr),
        .osc_i     (osc_i.ext),
        .done_o    (ext_done)
    );

    tsc_ost u_t1_ost (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .clr_i     (t1_clr),
        .osc_i     (osc_i.t1),
        .done_o    (t1_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Wait conditions

    always_comb begin
        lim_hit = 1'b0;
        if (r.st == tsc_pkg::ST_WAKE) begin
            if (ts_en || r.tgt == tsc_pkg::SRC_HF || r.tgt == tsc_pkg::SRC_LF) begin
                lim_hit = r.cnt >= 10'(tsc_pkg::WARM_CYC);
            end else if (r.tgt == tsc_pkg::SRC_T1) begin
                lim_hit = t1_done;
            end else if (xtal) begin
                lim_hit = ext_done;
            end else begin
                lim_hit = r.cnt >= 10'(tsc_pkg::EXT_WAKE_EDGES);
            end
        end else begin
            unique case (r.tgt)
                tsc_pkg::SRC_HF:  lim_hit = r.cnt >= 10'(tsc_pkg::INT_SW_CYC);
                tsc_pkg::SRC_LF:  lim_hit = 1'b1;
                tsc_pkg::SRC_EXT: lim_hit = !xtal || ext_done;
                tsc_pkg::SRC_T1:  lim_hit = t1_done;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r       = r;
        next_r.prev  = osc_v;
        next_r.rdata = 8'h00;

        if (bus_i.wr && bus_i.addr == tsc_pkg::ADDR_CFG) begin
            next_r.cfg = bus_i.wdata[5:0];
        end
        if (bus_i.wr && bus_i.addr == tsc_pkg::ADDR_CTRL) begin
            next_r.ctrl = bus_i.wdata[3:0];
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                tsc_pkg::ADDR_CFG:  next_r.rdata = {2'b00, r.cfg};
                tsc_pkg::ADDR_CTRL: next_r.rdata = {4'h0, r.ctrl};
                tsc_pkg::ADDR_STAT: next_r.rdata = {2'b00, r.src, 1'b0, r.run,
                                                    r.pll_rdy, r.flag};
                default:            next_r.rdata = 8'h00;
            endcase
        end

        // Multiplier lock time runs independently of the source machine
        if (!r.ctrl[tsc_pkg::CTRL_PLL]) begin
            next_r.pll_cnt = 18'h0_0000;
            next_r.pll_rdy = 1'b0;
        end else if (!r.pll_rdy) begin
            next_r.pll_cnt = r.pll_cnt + 18'h0_0001;
            next_r.pll_rdy = (r.pll_cnt == 18'(PLL_CYC - 1));
        end

        // Core clock follows its source; held low across a switch
        next_r.clk_out = osc_v[r.src];

        unique case (r.st)
            tsc_pkg::ST_POR, tsc_pkg::ST_SLEEP: begin
                next_r.clk_out = 1'b0;
                if (ost_clr) begin
                    next_r.st   = tsc_pkg::ST_WAKE;
                    next_r.tgt  = want;
                    next_r.cnt  = 10'h000;
                    next_r.flag = 1'b0;
                end
            end
            tsc_pkg::ST_WAKE: begin
                next_r.clk_out = 1'b0;
                if (r.tgt == tsc_pkg::SRC_EXT && !xtal && !ts_en) begin
                    next_r.cnt = r.cnt + {9'h000, rise[tsc_pkg::SRC_EXT]};
                end else begin
                    next_r.cnt = r.cnt + 10'h001;
                end
                if (lim_hit) begin
                    next_r.run = 1'b1;
                    if (ts_en) begin
                        next_r.src = tsc_pkg::SRC_HF;
                        next_r.st  = tsc_pkg::ST_TWO;
                    end else begin
                        next_r.src  = r.tgt;
                        next_r.st   = tsc_pkg::ST_RUN;
                        next_r.flag = r.tgt == tsc_pkg::SRC_EXT && xtal;
                    end
                end
            end
            tsc_pkg::ST_TWO: begin
                // Sleep wins over a count finishing in the same cycle
                if (ext_done && !sleep_i) begin
                    next_r.flag = 1'b1;
                    next_r.tgt  = tsc_pkg::SRC_EXT;
                    next_r.st   = tsc_pkg::ST_OLD;
                end
            end
            tsc_pkg::ST_RUN: begin
                if (want != r.src) begin
                    next_r.tgt = want;
                    next_r.cnt = 10'h000;
                    next_r.st  = tsc_pkg::ST_PREP;
                end
            end
            tsc_pkg::ST_PREP: begin
                next_r.tgt = want;
                next_r.cnt = (want == r.tgt) ? r.cnt + 10'h001 : 10'h000;
                if (want == r.src) begin
                    next_r.st = tsc_pkg::ST_RUN;
                end else if (want == r.tgt && lim_hit) begin
                    next_r.st = tsc_pkg::ST_OLD;
                end
            end
            tsc_pkg::ST_OLD: begin
                if (fall[r.src]) begin
                    next_r.clk_out = 1'b0;
                    next_r.st      = tsc_pkg::ST_NEW;
                end
            end
            tsc_pkg::ST_NEW: begin
                next_r.clk_out = 1'b0;
                if (fall[r.tgt]) begin
                    next_r.src = r.tgt;
                    next_r.st  = tsc_pkg::ST_RUN;
                    if (r.tgt == tsc_pkg::SRC_EXT && xtal) begin
                        next_r.flag = 1'b1;
                    end
                end
            end
        endcase

        if (sleep_i && r.st != tsc_pkg::ST_POR && r.st != tsc_pkg::ST_SLEEP
            && r.st != tsc_pkg::ST_WAKE) begin
            next_r.st      = tsc_pkg::ST_SLEEP;
            next_r.run     = 1'b0;
            next_r.clk_out = 1'b0;
            next_r.flag    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            r      <= '0;
            r.cfg  <= tsc_pkg::CFG_RST;
            r.ctrl <= tsc_pkg::CTRL_RST;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o       = r.rdata;
    assign sys_clk_o     = r.clk_out;
    assign src_o         = r.src;
    assign run_o         = r.run;
    assign ext_running_o = r.flag;
    assign pll_rdy_o     = r.pll_rdy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_two_speed;
        r.st == tsc_pkg::ST_TWO;
    endsequence

    sequence s_sleep_cmd;
        sleep_i && !ext_done;
    endsequence

    a_sleep_aborts: assert property (s_two_speed ##0 s_sleep_cmd
        |=> r.st == tsc_pkg::ST_SLEEP && !r.flag ##1 !r.flag)
        else $error("sleep did not abort the start-up period");

    a_flag_after_count: assert property ($rose(r.flag) |-> $past(ext_done)
        && $past(r.st) != tsc_pkg::ST_SLEEP)
        else $error("running flag set without a finished count");

    a_two_speed_int: assert property (s_two_speed |-> r.src == tsc_pkg::SRC_HF
        && r.run)
        else $error("two-speed period not on internal oscillator");

    a_two_speed_cfg: assert property ($rose(r.st == tsc_pkg::ST_TWO) |-> $past(ts_en))
        else $error("two-speed entered without its configuration");

    a_sleep_clears: assert property ($rose(r.st == tsc_pkg::ST_SLEEP) |-> !r.flag
        && !r.run && !r.clk_out)
        else $error("sleep entry left flag, run or clock set");

    a_wake_ec_edges: assert property (r.st == tsc_pkg::ST_WAKE && !ts_en
        && r.tgt == tsc_pkg::SRC_EXT && !xtal && r.cnt < 10'(tsc_pkg::EXT_WAKE_EDGES)
        |=> !r.run)
        else $error("external clock used before two edges");

    a_int_switch_wait: assert property ($rose(r.st == tsc_pkg::ST_OLD)
        && r.tgt == tsc_pkg::SRC_HF |-> $past(r.cnt) >= 10'(tsc_pkg::INT_SW_CYC))
        else $error("internal switch shorter than its delay");

    a_switch_glitch: assert property (r.st == tsc_pkg::ST_OLD && fall[r.src]
        |=> !r.clk_out [*2])
        else $error("clock not held low across a switch");

    a_pll_lock: assert property ($rose(r.pll_rdy) |-> $past(r.pll_cnt)
        == 18'(PLL_CYC - 1))
        else $error("multiplier ready before lock time");

    a_read_once: assert property (!$past(bus_i.rd) |-> r.rdata == 8'h00)
        else $error("read data outside its cycle");

endmodule
